// ---- alu_arith_flags.sv ----
`timescale 1ns/1ps
// combinational carry, overflow and auxiliary carry for add, subtract, multiply and divide
module alu_arith_flags
	import alu_flag_pkg::*;
(
	input wire alu_op_e op,
	input wire logic [7:0] operand_a,
	input wire logic [7:0] operand_b,
	input wire logic carry_in,
	output logic arith_carry,
	output logic arith_overflow,
	output logic arith_aux_carry
);

	logic cin;
	logic [8:0] sum_full;
	logic [7:0] sum_low7;
	logic [4:0] sum_nib;
	logic [8:0] diff_full;
	logic [7:0] diff_low7;
	logic [4:0] diff_nib;
	logic [15:0] product;
	logic add_ov;
	logic sub_ov;
	logic is_sub;
	logic is_mul;
	logic is_div;

	// plain add ignores the incoming carry
	assign cin = (op == add_op) ? 1'b0 : carry_in;

	// sums with carry out of bit 7, bit 6 and bit 3
	assign sum_full = {1'b0, operand_a} + {1'b0, operand_b} + {8'h00, cin};
	assign sum_low7 = {1'b0, operand_a[6:0]} + {1'b0, operand_b[6:0]} + {7'h00, cin};
	assign sum_nib = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, cin};
	assign add_ov = sum_full[8] ^ sum_low7[7];

	// differences with borrow into bit 7, bit 6 and bit 3
	assign diff_full = {1'b0, operand_a} - {1'b0, operand_b} - {8'h00, carry_in};
	assign diff_low7 = {1'b0, operand_a[6:0]} - {1'b0, operand_b[6:0]} - {7'h00, carry_in};
	assign diff_nib = {1'b0, operand_a[3:0]} - {1'b0, operand_b[3:0]} - {4'h0, carry_in};
	assign sub_ov = diff_full[8] ^ diff_low7[7];

	assign product = {8'h00, operand_a} * {8'h00, operand_b};
	assign is_sub = (op == subtract_with_borrow_op);
	assign is_mul = (op == product_op);
	assign is_div = (op == divide_op);

	// multiply and divide force carry low; divide by zero flags overflow
	assign arith_carry = (is_mul || is_div) ? 1'b0 : (is_sub ? diff_full[8] : sum_full[8]);
	assign arith_overflow = is_mul ? (product > PRODUCT_BYTE_MAX) :
		is_div ? (operand_b == ZERO_BYTE) :
		is_sub ? sub_ov : add_ov;
	assign arith_aux_carry = is_sub ? diff_nib[4] : sum_nib[4];

endmodule

// ---- alu_flag_pkg.sv ----
package alu_flag_pkg;

	// flag operations presented by the instruction decoder
	typedef enum logic [3:0] {
		no_flag_op = 4'b0000,
		add_op = 4'b0001,
		add_with_carry_op = 4'b0010,
		subtract_with_borrow_op = 4'b0011,
		product_op = 4'b0100,
		divide_op = 4'b0101,
		decimal_adjust_op = 4'b0110,
		rotate_right_through_carry = 4'b0111,
		rotate_left_through_carry = 4'b1000,
		force_carry_high = 4'b1001,
		force_carry_low = 4'b1010,
		invert_carry = 4'b1011,
		carry_and_bit = 4'b1100,
		carry_or_bit = 4'b1101,
		bit_to_carry_move = 4'b1110,
		compare_jump_not_equal = 4'b1111
	} alu_op_e;

	// apb register map
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] FLAG_REG_ADDR = 12'h000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// field positions inside the flag register
	localparam int CARRY_POS = 7;
	localparam int AUX_CARRY_POS = 6;
	localparam int OVERFLOW_POS = 2;
	localparam int USER_POS = 1;
	localparam int PARITY_POS = 0;

	// reset values
	localparam logic FLAG_RESET = 1'b0;

	// arithmetic constants
	localparam logic [15:0] PRODUCT_BYTE_MAX = 16'h00FF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [8:0] DA_LOW_ADJ = 9'h006;
	localparam logic [8:0] DA_HIGH_ADJ = 9'h060;

endpackage

// ---- alu_flag_sva.sv ----
`timescale 1ns/1ps
module alu_flag_sva
	import alu_flag_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic op_valid,
	input wire alu_op_e op,
	input wire logic [7:0] operand_a,
	input wire logic [7:0] operand_b,
	input wire logic [7:0] acc_value,
	input wire logic carry_flag,
	input wire logic auxiliary_carry_flag,
	input wire logic signed_overflow_flag,
	input wire logic user_flag_one,
	input wire logic parity_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// expected flags from the operands seen at the writeback edge
	wire logic [7:0] a = operand_a;
	wire logic [7:0] b = operand_b;
	wire logic ci = carry_flag & (op != add_op);
	wire logic c6 = a[6:0] + b[6:0] + ci > 8'h7F;
	wire logic c7 = a + b + ci > 9'h0FF;
	wire logic [1:0] add_exp = {c7, c6 ^ c7};
	wire logic big = a * b > 16'h00FF;
	wire logic nil = b == 8'h00;
	wire logic hi = op == force_carry_high;
	wire logic rot = op == rotate_right_through_carry ? a[0] : a[7];
	sequence took(alu_op_e k);
		op_valid && op == k;
	endsequence
	a_add_overflow: assert property (
		op_valid && op inside {add_op, add_with_carry_op} |=>
		{carry_flag, signed_overflow_flag} == $past(add_exp)) else $error("add flags wrong");
	a_mul_flags: assert property (
		took(product_op) |=> !carry_flag && signed_overflow_flag == $past(big)
		&& $stable(auxiliary_carry_flag)) else $error("multiply flags wrong");
	a_div_flags: assert property (
		took(divide_op) |=> !carry_flag && signed_overflow_flag == $past(nil))
		else $error("divide flags wrong");
	a_user_kept: assert property (
		op_valid && !psel |=> $stable(user_flag_one)) else $error("user flag moved");
	a_parity_track: assert property (
		1'h1 |=> parity_flag == ^$past(acc_value)) else $error("parity wrong");
	a_carry_force: assert property (
		op_valid && op inside {force_carry_high, force_carry_low} |=>
		carry_flag == $past(hi)) else $error("forced carry wrong");
	a_invert_carry: assert property (
		took(invert_carry) |=> carry_flag != $past(carry_flag)) else $error("invert wrong");
	a_rotate_carry: assert property (
		op_valid && op inside {rotate_right_through_carry, rotate_left_through_carry}
		|=> carry_flag == $past(rot)) else $error("rotate carry wrong");
endmodule
////////////////////////////////
bind alu_status_flag_logic alu_flag_sva sva (.*);

// ---- alu_status_flag_logic.sv ----
// Summary of operation
// - add and add-with-carry set overflow when exactly one of bits 6, 7 carries.
// - subtract-with-borrow sets overflow when borrow enters exactly one of bits 6, 7.
// - multiply sets overflow when product exceeds 255, clears carry, keeps aux carry.
// - divide clears overflow and carry; a zero divisor sets overflow instead.
// - user flag is free for software and untouched by any operation.
// - parity flag is one for odd count of ones in accumulator.
// - add, add-with-carry and subtract update carry, overflow and aux carry.
// - carry set, clear, invert, bit logic, move, compare, rotates, decimal adjust touch carry.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module alu_status_flag_logic
	import alu_flag_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_valid,
	input wire alu_op_e op,
	input wire logic [7:0] operand_a,
	input wire logic [7:0] operand_b,
	input wire logic bit_operand,
	input wire logic bit_invert,
	input wire logic [7:0] acc_value,
	output logic carry_flag,
	output logic auxiliary_carry_flag,
	output logic signed_overflow_flag,
	output logic user_flag_one,
	output logic parity_flag
);

	////////////////////////////////////////////////////////////////////////////////
	// flag state

	// flag registers and their next values
	logic carry_reg;
	logic carry_next;
	logic aux_carry_reg;
	logic aux_carry_next;
	logic overflow_reg;
	logic overflow_next;
	logic user_reg;
	logic user_next;
	logic parity_reg;
	logic parity_next;

	// results of the arithmetic flag unit
	logic arith_carry;
	logic arith_overflow;
	logic arith_aux_carry;

	// outputs come straight from the flag flip-flops
	assign carry_flag = carry_reg;
	assign auxiliary_carry_flag = aux_carry_reg;
	assign signed_overflow_flag = overflow_reg;
	assign user_flag_one = user_reg;
	assign parity_flag = parity_reg;

	////////////////////////////////////////////////////////////////////////////////
	// apb slave

	// bus-side answer registers and decode
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic setup_phase;
	logic access_done;
	logic addr_hit;
	logic sw_write;
	logic lane0_write;
	logic [31:0] flag_word;
	logic sw_carry;
	logic sw_aux_carry;
	logic sw_overflow;
	logic sw_user;

	// no wait state: ready rises in the first access cycle, right after setup
	// the answer is registered so pready, pslverr and prdata all leave flip-flops;
	// there is no extra cycle, as the answer is prepared during the setup cycle
	// the flag register is the only mapped word; every other address errors
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_reg;
	assign addr_hit = (paddr == FLAG_REG_ADDR);
	assign sw_write = access_done && pwrite && addr_hit;
	assign lane0_write = sw_write && pstrb[0];

	// flag fields carried by the low byte of a software write
	assign sw_carry = pwdata[CARRY_POS];
	assign sw_aux_carry = pwdata[AUX_CARRY_POS];
	assign sw_overflow = pwdata[OVERFLOW_POS];
	assign sw_user = pwdata[USER_POS];

	// read view of the flags, upper bits zero
	always_comb begin
		flag_word = READ_ZERO;
		flag_word[CARRY_POS] = carry_reg;
		flag_word[AUX_CARRY_POS] = aux_carry_reg;
		flag_word[OVERFLOW_POS] = overflow_reg;
		flag_word[USER_POS] = user_reg;
		flag_word[PARITY_POS] = parity_reg;
	end

	// answer prepared during setup, valid in the access cycle
	// pslverr rises with pready for unmapped words; their writes are dropped
	assign pready_next = setup_phase;
	assign pslverr_next = setup_phase && !addr_hit;
	assign prdata_next = (setup_phase && !pwrite && addr_hit) ? flag_word : READ_ZERO;

	// ready register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= pready_next;
		end
	end

	// error register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= pslverr_next;
		end
	end

	// read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= READ_ZERO;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	// bus outputs taken directly from the answer registers
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// arithmetic flag evaluation

	// the unit sees the current carry as its incoming carry
	alu_arith_flags u_arith (
		.op(op),
		.operand_a(operand_a),
		.operand_b(operand_b),
		.carry_in(carry_reg),
		.arith_carry(arith_carry),
		.arith_overflow(arith_overflow),
		.arith_aux_carry(arith_aux_carry)
	);

	////////////////////////////////////////////////////////////////////////////////
	// carry-only operations

	// intermediate values of the carry-only operations
	logic sel_bit;
	logic low_adjust;
	logic [8:0] da_first;
	logic high_adjust;
	logic [8:0] da_second;
	logic da_carry;
	logic cmp_less;

	// optional complemented source bit for and/or into carry
	// the move ignores the invert input and copies the bit as it is
	assign sel_bit = bit_invert ? !bit_operand : bit_operand;

	// decimal adjust carry: nibble corrections of 6 and 60h
	// a carry already set is kept, as the adjust can only raise it
	assign low_adjust = (operand_a[3:0] > BCD_DIGIT_MAX) || aux_carry_reg;
	assign da_first = {1'b0, operand_a} + (low_adjust ? DA_LOW_ADJ : 9'h000);
	assign high_adjust = (da_first[7:4] > BCD_DIGIT_MAX) || carry_reg || da_first[8];
	assign da_second = {1'b0, da_first[7:0]} + (high_adjust ? DA_HIGH_ADJ : 9'h000);
	assign da_carry = carry_reg || da_first[8] || da_second[8];

	// compare sets carry when the first operand is below the second
	// unsigned compare, the jump does not look at sign
	assign cmp_less = (operand_a < operand_b);

	////////////////////////////////////////////////////////////////////////////////
	// next flag values

	// software write lands first; an operation in the same cycle wins its fields
	// no default branch: every four-bit code is a defined operation
	always_comb begin
		carry_next = carry_reg;
		aux_carry_next = aux_carry_reg;
		overflow_next = overflow_reg;
		user_next = user_reg;
		if (lane0_write) begin
			carry_next = sw_carry;
			aux_carry_next = sw_aux_carry;
			overflow_next = sw_overflow;
			user_next = sw_user;
		end
		if (op_valid) begin
			unique case (op)
				no_flag_op: begin
				end
				add_op, add_with_carry_op, subtract_with_borrow_op: begin
					carry_next = arith_carry;
					overflow_next = arith_overflow;
					aux_carry_next = arith_aux_carry;
				end
				product_op, divide_op: begin
					carry_next = arith_carry;
					overflow_next = arith_overflow;
				end
				decimal_adjust_op: begin
					carry_next = da_carry;
				end
				rotate_right_through_carry: begin
					carry_next = operand_a[0];
				end
				rotate_left_through_carry: begin
					carry_next = operand_a[7];
				end
				force_carry_high: begin
					carry_next = 1'b1;
				end
				force_carry_low: begin
					carry_next = 1'b0;
				end
				invert_carry: begin
					carry_next = !carry_reg;
				end
				carry_and_bit: begin
					carry_next = carry_reg && sel_bit;
				end
				carry_or_bit: begin
					carry_next = carry_reg || sel_bit;
				end
				bit_to_carry_move: begin
					carry_next = bit_operand;
				end
				compare_jump_not_equal: begin
					carry_next = cmp_less;
				end
			endcase
		end
	end

	// parity follows the accumulator every cycle
	// it trails the accumulator by one clock and no operation can disturb it
	assign parity_next = ^acc_value;

	// carry flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_reg <= FLAG_RESET;
		end else begin
			carry_reg <= carry_next;
		end
	end

	// auxiliary carry flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_carry_reg <= FLAG_RESET;
		end else begin
			aux_carry_reg <= aux_carry_next;
		end
	end

	// signed overflow flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_reg <= FLAG_RESET;
		end else begin
			overflow_reg <= overflow_next;
		end
	end

	// user flag register, written by software only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_reg <= FLAG_RESET;
		end else begin
			user_reg <= user_next;
		end
	end

	// parity flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parity_reg <= FLAG_RESET;
		end else begin
			parity_reg <= parity_next;
		end
	end

endmodule

// ---- core_op_model.sv ----
`timescale 1ns/1ps
module core_op_model
	import alu_flag_pkg::*;
(
	input wire logic pclk,
	output logic op_valid,
	output alu_op_e op,
	output logic [7:0] operand_a,
	output logic [7:0] operand_b,
	output logic bit_operand,
	output logic bit_invert,
	output logic [7:0] acc_value
);
	// datapath idles with no writeback pending
	initial begin
		{op_valid, operand_a, operand_b, bit_operand, bit_invert, acc_value} = '0;
		op = no_flag_op;
	end
	// one writeback pulse; operands are scrambled after it so stale values never match
	task automatic issue(input alu_op_e o, input logic [7:0] x, input logic [7:0] y,
		input logic [1:0] bb);
		@(posedge pclk);
		{op_valid, operand_a, operand_b, acc_value} <= {1'h1, x, y, x};
		op <= o;
		{bit_invert, bit_operand} <= bb;
		@(posedge pclk);
		{op_valid, operand_a, operand_b} <= {1'h0, ~x, ~y};
	endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench
	import alu_flag_pkg::*;
;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = '0;
	logic pready, pslverr, op_valid, bit_operand, bit_invert, carry_flag, user_flag_one;
	logic auxiliary_carry_flag, signed_overflow_flag, parity_flag;
	alu_op_e op;
	logic [7:0] operand_a, operand_b, acc_value;
	int failures = 0, num_checks = 0;
	// clock, flag logic and core model
	always #5 pclk = ~pclk;
	alu_status_flag_logic dut (.*);
	core_op_model core (.*);
	////////////////////////////////
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one transfer; read data and error are taken at the pready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'h1, w, a, d, s};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 9);
		if (pready !== 1'h1) begin
			failures++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	// preload flags, issue one op, compare after the writeback edge has landed
	task automatic run(input alu_op_e o, input logic [15:0] ab, input logic [1:0] bb,
		input logic [7:0] fl, input logic [2:0] e);
		apb(1'h1, FLAG_REG_ADDR, {24'h00_0000, fl}, 4'h1);
		core.issue(o, ab[15:8], ab[7:0], bb);
		#1;
		chk({27'h000_0000, carry_flag, auxiliary_carry_flag, signed_overflow_flag,
			user_flag_one, parity_flag}, {27'h000_0000, e, fl[USER_POS], ^ab[15:8]});
	endtask
	task automatic t_regs();
		apb(1'h1, 12'h004, 32'hFFFF_FFFF, 4'hF);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		apb(1'h0, 12'h004, 32'h0000_0000, 4'h0);
		chk(rd, READ_ZERO);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		apb(1'h1, FLAG_REG_ADDR, 32'hFFFF_FFFF, 4'h0);
		apb(1'h0, FLAG_REG_ADDR, 32'h0000_0000, 4'h0);
		chk(rd, READ_ZERO);
		apb(1'h1, FLAG_REG_ADDR, 32'hFFFF_FFFF, 4'hF);
		apb(1'h0, FLAG_REG_ADDR, 32'h0000_0000, 4'h0);
		chk(rd, 32'h0000_00C6);
		chk({31'h0000_0000, er}, 32'h0000_0000);
	endtask
	task automatic t_arith();
		run(add_op, 16'h7F01, 2'h0, 8'h80, 3'h3);
		run(add_with_carry_op, 16'hFF00, 2'h0, 8'h80, 3'h6);
		run(subtract_with_borrow_op, 16'h8001, 2'h0, 8'h00, 3'h3);
		run(subtract_with_borrow_op, 16'h0000, 2'h0, 8'h80, 3'h6);
		run(product_op, 16'h1010, 2'h0, 8'hC0, 3'h3);
		run(product_op, 16'h0203, 2'h0, 8'h84, 3'h0);
		run(divide_op, 16'h1000, 2'h0, 8'h82, 3'h1);
		run(divide_op, 16'h1002, 2'h0, 8'hC4, 3'h2);
	endtask
	task automatic t_carry();
		run(no_flag_op, 16'h0000, 2'h0, 8'hC6, 3'h7);
		run(force_carry_high, 16'h0000, 2'h0, 8'h46, 3'h7);
		run(invert_carry, 16'h0000, 2'h0, 8'hC6, 3'h3);
		run(carry_and_bit, 16'h0000, 2'h3, 8'hC6, 3'h3);
		run(carry_or_bit, 16'h0000, 2'h2, 8'h46, 3'h7);
		run(bit_to_carry_move, 16'h0000, 2'h2, 8'hC6, 3'h3);
		run(compare_jump_not_equal, 16'h1235, 2'h0, 8'h46, 3'h7);
		run(rotate_right_through_carry, 16'h9A00, 2'h0, 8'hC6, 3'h3);
		run(rotate_left_through_carry, 16'h9A00, 2'h0, 8'h46, 3'h7);
		run(decimal_adjust_op, 16'h9A00, 2'h0, 8'h06, 3'h5);
	endtask
	// reset for 16 cycles, then the scenarios
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_arith();
		t_carry();
		finish_test();
	end
endmodule
